// >>> pkg/blv_defs.vh
// Purpose: constants for the boost loop and voltage configuration registers
// Assumes: 8-bit registers, 7-bit address, spi mode 0 frames of 16 bits
// Notes:   gain and voltage figures are fixed point scaled integers
`ifndef BLV_DEFS_VH
`define BLV_DEFS_VH
`define BLV_ADDR_W          7
`define BLV_OFS_VOUT1       7'h03
`define BLV_OFS_VOUT2       7'h04
`define BLV_OFS_PROP        7'h11
`define BLV_OFS_INTEG       7'h12
`define BLV_OFS_SLOPE       7'h13
`define BLV_OFS_SENSE       7'h14
`define BLV_RST_VAL         8'h00
`define BLV_HI_MSB          7
`define BLV_HI_LSB          4
`define BLV_LO_MSB          3
`define BLV_LO_LSB          0
// gains in units of 0.005 (kp) and 0.0005 (ki): step 10, offset 10
`define BLV_GAIN_STEP       8'h0A
`define BLV_GAIN_OFS        8'h0A
// slope resistance in kilohm
`define BLV_SLP_R0          8'h70
`define BLV_SLP_R1          8'h54
`define BLV_SLP_R2          8'h46
`define BLV_SLP_R4          8'h38
`define BLV_SLP_R8          8'h1C
// sense resistance in ohm
`define BLV_SNS_R0          11'h0FA
`define BLV_SNS_R1          11'h1F4
`define BLV_SNS_R2          11'h3E8
`define BLV_SNS_R3          11'h5DC
// target voltage in mV: code times 355.5 mV, as code*3555/10
`define BLV_MV_PER_CODE_X10 12'hDE3
// temperature scale in ppm: 333 per degree around 38
`define BLV_TC_PPM          9'h14D
`define BLV_TC_REF          8'h26
`define BLV_PPM_ONE         21'h0F4240
`endif

// >>> src/blv_target_scale.v
// Purpose: temperature scaled target voltage for one output
// Assumes: tj code is junction temperature reading, unsigned
// Notes:   output is registered millivolts, zero when the output is off
`timescale 1ns/100ps
`include "blv_defs.vh"
module blv_target_scale (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // inputs
  input  wire [7:0]  code,
  input  wire [7:0]  tj_code,
  // outputs
  output reg         out_on,
  output reg  [16:0] target_mv
);
  wire signed [9:0]  tdelta;
  wire signed [21:0] factor_ppm;
  wire        [19:0] base_mv_x10;
  wire signed [43:0] prod;
  wire signed [43:0] mv_full;
  assign tdelta      = $signed({2'b00, tj_code}) - $signed({2'b00, `BLV_TC_REF});
  assign factor_ppm  = $signed({1'b0, `BLV_PPM_ONE}) + tdelta * $signed({1'b0, `BLV_TC_PPM});
  assign base_mv_x10 = code * `BLV_MV_PER_CODE_X10;
  assign prod        = $signed({24'h000000, base_mv_x10}) * factor_ppm;
  assign mv_full     = prod / $signed(44'h00000989680);
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      out_on    <= 1'b0;
      target_mv <= 17'h00000;
    end else begin
      out_on    <= (code != 8'h00);
      if (code == 8'h00) begin
        target_mv <= 17'h00000;
      end else if (mv_full[43]) begin
        target_mv <= 17'h00000;
      end else begin
        target_mv <= mv_full[16:0];
      end
    end
  end
endmodule // blv_target_scale

// >>> src/blv_config_regs.v
// Purpose: spi reachable loop tuning and target voltage registers
// Assumes: spi mode 0, msb first, frame = rw bit, 7-bit address, 8-bit data
// Notes:   rw bit high means write; reads return data in the second byte
`timescale 1ns/100ps
`include "blv_defs.vh"
module blv_config_regs (
  // clock and reset
  input  wire        core_clk,
  input  wire        reset,
  // spi pins
  input  wire        spi_sclk,
  input  wire        spi_cs_n,
  input  wire        spi_mosi,
  output reg         spi_miso,
  output wire        spi_miso_oe,
  // temperature reading
  input  wire [7:0]  tj_code,
  // raw codes to the loops
  output reg  [3:0]  kp_code_out_one,
  output reg  [3:0]  kp_code_out_two,
  output reg  [3:0]  ki_code_out_one,
  output reg  [3:0]  ki_code_out_two,
  output reg  [3:0]  slope_comp_code_out_one,
  output reg  [3:0]  slope_comp_code_out_two,
  output reg  [1:0]  sense_res_code_drv_one,
  output reg  [1:0]  sense_res_code_drv_two,
  output reg  [1:0]  sense_res_code_drv_three,
  output reg  [1:0]  sense_res_code_drv_four,
  // decoded loop settings
  output reg  [7:0]  kp_out_one,
  output reg  [7:0]  kp_out_two,
  output reg  [7:0]  ki_out_one,
  output reg  [7:0]  ki_out_two,
  output reg  [7:0]  slope_kohm_out_one,
  output reg  [7:0]  slope_kohm_out_two,
  output reg  [43:0] sense_ohm_drv,
  // targets
  output wire        out_one_on,
  output wire        out_two_on,
  output wire [16:0] target_mv_out_one,
  output wire [16:0] target_mv_out_two
);
  reg  [7:0]  target_voltage_out_one;
  reg  [7:0]  target_voltage_out_two;
  reg  [7:0]  loop_proportional_gain;
  reg  [7:0]  loop_integral_gain;
  reg  [7:0]  slope_compensation_factor;
  reg  [7:0]  sense_slope_resistor_select;
  reg  [2:0]  sclk_sync;
  reg  [1:0]  cs_sync;
  reg  [1:0]  mosi_sync;
  reg  [3:0]  bit_cnt;
  reg  [14:0] shift_in;
  reg  [7:0]  shift_out;
  reg  [7:0]  rd_data;
  reg  [7:0]  tj_s1;
  reg  [7:0]  tj_s2;
  wire        sclk_rise;
  wire        sclk_fall;
  wire        cs_act;
  wire        frame_done;
  wire [6:0]  addr;
  wire        wr_bit;
  wire [7:0]  wr_data;
  wire [6:0]  rd_addr;
  wire [43:0] next_sense_ohm_drv;

  function [7:0] slope_kohm;
    input [3:0] c;
    begin
      case (c)
        4'h0:    slope_kohm = `BLV_SLP_R0;
        4'h1:    slope_kohm = `BLV_SLP_R1;
        4'h2:    slope_kohm = `BLV_SLP_R2;
        4'h4:    slope_kohm = `BLV_SLP_R4;
        4'h8:    slope_kohm = `BLV_SLP_R8;
        default: slope_kohm = `BLV_SLP_R0;
      endcase
    end
  endfunction

  function [7:0] gain_units;
    input [3:0] c;
    begin
      gain_units = c * `BLV_GAIN_STEP + `BLV_GAIN_OFS;
    end
  endfunction

  // pin synchronisers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sclk_sync <= 3'h0;
      cs_sync   <= 2'h3;
      mosi_sync <= 2'h0;
      tj_s1     <= 8'h00;
      tj_s2     <= 8'h00;
    end else begin
      sclk_sync <= {sclk_sync[1:0], spi_sclk};
      cs_sync   <= {cs_sync[0], spi_cs_n};
      mosi_sync <= {mosi_sync[0], spi_mosi};
      tj_s1     <= tj_code;
      tj_s2     <= tj_s1;
    end
  end

  assign sclk_rise   = sclk_sync[1] & ~sclk_sync[2];
  assign sclk_fall   = ~sclk_sync[1] & sclk_sync[2];
  assign cs_act      = ~cs_sync[1];
  assign spi_miso_oe = cs_act;
  assign frame_done  = cs_act & sclk_rise & (bit_cnt == 4'hF);
  assign addr        = shift_in[13:7];
  assign wr_bit      = shift_in[14];
  assign wr_data     = {shift_in[6:0], mosi_sync[1]};
  // address lsb still in the synchroniser on the eighth rise
  assign rd_addr     = {shift_in[5:0], mosi_sync[1]};

  // read mux, unmapped reads zero
  always @* begin
    case (rd_addr)
      `BLV_OFS_VOUT1: rd_data = target_voltage_out_one;
      `BLV_OFS_VOUT2: rd_data = target_voltage_out_two;
      `BLV_OFS_PROP:  rd_data = loop_proportional_gain;
      `BLV_OFS_INTEG: rd_data = loop_integral_gain;
      `BLV_OFS_SLOPE: rd_data = slope_compensation_factor;
      `BLV_OFS_SENSE: rd_data = sense_slope_resistor_select;
      default:        rd_data = 8'h00;
    endcase
  end

  // frame shifter
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      bit_cnt   <= 4'h0;
      shift_in  <= 15'h0000;
      shift_out <= 8'h00;
      spi_miso  <= 1'b0;
    end else if (!cs_act) begin
      bit_cnt   <= 4'h0;
      shift_out <= 8'h00;
      spi_miso  <= 1'b0;
    end else begin
      if (sclk_rise) begin
        bit_cnt  <= bit_cnt + 4'h1;
        shift_in <= {shift_in[13:0], mosi_sync[1]};
        if (bit_cnt == 4'h7) begin
          shift_out <= rd_data;
        end
      end
      if (sclk_fall && bit_cnt >= 4'h8) begin
        spi_miso  <= shift_out[7];
        shift_out <= {shift_out[6:0], 1'b0};
      end
    end
  end

  // register writes
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      target_voltage_out_one      <= `BLV_RST_VAL;
      target_voltage_out_two      <= `BLV_RST_VAL;
      loop_proportional_gain      <= `BLV_RST_VAL;
      loop_integral_gain          <= `BLV_RST_VAL;
      slope_compensation_factor   <= `BLV_RST_VAL;
      sense_slope_resistor_select <= `BLV_RST_VAL;
    end else if (frame_done && wr_bit) begin
      case (addr)
        `BLV_OFS_VOUT1: target_voltage_out_one      <= wr_data;
        `BLV_OFS_VOUT2: target_voltage_out_two      <= wr_data;
        `BLV_OFS_PROP:  loop_proportional_gain      <= wr_data;
        `BLV_OFS_INTEG: loop_integral_gain          <= wr_data;
        `BLV_OFS_SLOPE: slope_compensation_factor   <= wr_data;
        `BLV_OFS_SENSE: sense_slope_resistor_select <= wr_data;
        default: ;
      endcase
    end
  end

  // decoded settings
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      kp_code_out_one          <= 4'h0;
      kp_code_out_two          <= 4'h0;
      ki_code_out_one          <= 4'h0;
      ki_code_out_two          <= 4'h0;
      slope_comp_code_out_one  <= 4'h0;
      slope_comp_code_out_two  <= 4'h0;
      sense_res_code_drv_one   <= 2'h0;
      sense_res_code_drv_two   <= 2'h0;
      sense_res_code_drv_three <= 2'h0;
      sense_res_code_drv_four  <= 2'h0;
      kp_out_one               <= `BLV_GAIN_OFS;
      kp_out_two               <= `BLV_GAIN_OFS;
      ki_out_one               <= `BLV_GAIN_OFS;
      ki_out_two               <= `BLV_GAIN_OFS;
      slope_kohm_out_one       <= `BLV_SLP_R0;
      slope_kohm_out_two       <= `BLV_SLP_R0;
    end else begin
      kp_code_out_two          <= loop_proportional_gain[`BLV_HI_MSB:`BLV_HI_LSB];
      kp_code_out_one          <= loop_proportional_gain[`BLV_LO_MSB:`BLV_LO_LSB];
      ki_code_out_two          <= loop_integral_gain[`BLV_HI_MSB:`BLV_HI_LSB];
      ki_code_out_one          <= loop_integral_gain[`BLV_LO_MSB:`BLV_LO_LSB];
      slope_comp_code_out_two  <= slope_compensation_factor[`BLV_HI_MSB:`BLV_HI_LSB];
      slope_comp_code_out_one  <= slope_compensation_factor[`BLV_LO_MSB:`BLV_LO_LSB];
      sense_res_code_drv_four  <= sense_slope_resistor_select[7:6];
      sense_res_code_drv_three <= sense_slope_resistor_select[5:4];
      sense_res_code_drv_two   <= sense_slope_resistor_select[3:2];
      sense_res_code_drv_one   <= sense_slope_resistor_select[1:0];
      kp_out_two               <= gain_units(loop_proportional_gain[7:4]);
      kp_out_one               <= gain_units(loop_proportional_gain[3:0]);
      ki_out_two               <= gain_units(loop_integral_gain[7:4]);
      ki_out_one               <= gain_units(loop_integral_gain[3:0]);
      slope_kohm_out_two       <= slope_kohm(slope_compensation_factor[7:4]);
      slope_kohm_out_one       <= slope_kohm(slope_compensation_factor[3:0]);
    end
  end

  // sense resistance per driver
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_sense
      assign next_sense_ohm_drv[g*11 +: 11] =
        (sense_slope_resistor_select[g*2 +: 2] == 2'h0) ? `BLV_SNS_R0 :
        (sense_slope_resistor_select[g*2 +: 2] == 2'h1) ? `BLV_SNS_R1 :
        (sense_slope_resistor_select[g*2 +: 2] == 2'h2) ? `BLV_SNS_R2 : `BLV_SNS_R3;
    end
  endgenerate

  // one register for all four drivers
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      sense_ohm_drv <= {4{`BLV_SNS_R0}};
    end else begin
      sense_ohm_drv <= next_sense_ohm_drv;
    end
  end

  // target voltages
  blv_target_scale u_scale_one (
    .core_clk  (core_clk),
    .reset     (reset),
    .code      (target_voltage_out_one),
    .tj_code   (tj_s2),
    .out_on    (out_one_on),
    .target_mv (target_mv_out_one)
  );

  blv_target_scale u_scale_two (
    .core_clk  (core_clk),
    .reset     (reset),
    .code      (target_voltage_out_two),
    .tj_code   (tj_s2),
    .out_on    (out_two_on),
    .target_mv (target_mv_out_two)
  );
endmodule // blv_config_regs

// >>> tb/blv_config_regs_monitor.sv
// Purpose: concurrent checks on the loop and target voltage register ports
// Assumes: one clock domain, async active high reset
// Notes:   decoded values checked whenever the raw code holds steady; sense resistance for drivers one and four only
`timescale 1ns/100ps
module blv_config_regs_monitor (
  // clock, reset, select
  input wire logic        core_clk,
  input wire logic        reset,
  input wire logic        spi_cs_n,
  // raw codes
  input wire logic [3:0]  kp_code_out_one,
  input wire logic [3:0]  kp_code_out_two,
  input wire logic [3:0]  ki_code_out_one,
  input wire logic [3:0]  ki_code_out_two,
  input wire logic [3:0]  slope_comp_code_out_one,
  input wire logic [3:0]  slope_comp_code_out_two,
  input wire logic [1:0]  sense_res_code_drv_one,
  input wire logic [1:0]  sense_res_code_drv_four,
  // decoded settings and targets
  input wire logic [7:0]  kp_out_one,
  input wire logic [7:0]  kp_out_two,
  input wire logic [7:0]  ki_out_one,
  input wire logic [7:0]  ki_out_two,
  input wire logic [7:0]  slope_kohm_out_one,
  input wire logic [7:0]  slope_kohm_out_two,
  input wire logic [43:0] sense_ohm_drv,
  input wire logic        out_one_on,
  input wire logic        out_two_on,
  input wire logic [16:0] target_mv_out_one,
  input wire logic [16:0] target_mv_out_two
);
  function automatic logic [7:0] gain(input logic [3:0] c);
    gain = {4'h0, c} * 8'h0A + 8'h0A;
  endfunction
  function automatic logic [7:0] slp(input logic [3:0] c);
    case (c)
      4'h1: slp = 8'h54;
      4'h2: slp = 8'h46;
      4'h4: slp = 8'h38;
      4'h8: slp = 8'h1C;
      default: slp = 8'h70;
    endcase
  endfunction
  function automatic logic [10:0] sns(input logic [1:0] c);
    sns = (c == 2'h0) ? 11'h0FA : (c == 2'h1) ? 11'h1F4 : (c == 2'h2) ? 11'h3E8 : 11'h5DC;
  endfunction
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_KP_ONE: assert property ($stable(kp_code_out_one) |-> kp_out_one == gain(kp_code_out_one))
    else $error("kp one decode wrong");
  AST_KP_TWO: assert property ($stable(kp_code_out_two) |-> kp_out_two == gain(kp_code_out_two))
    else $error("kp two decode wrong");
  AST_KI_ONE: assert property ($stable(ki_code_out_one) |-> ki_out_one == gain(ki_code_out_one))
    else $error("ki one decode wrong");
  AST_KI_TWO: assert property ($stable(ki_code_out_two) |-> ki_out_two == gain(ki_code_out_two))
    else $error("ki two decode wrong");
  AST_SLOPE_ONE: assert property ($stable(slope_comp_code_out_one) |->
    slope_kohm_out_one == slp(slope_comp_code_out_one)) else $error("slope one decode wrong");
  AST_SLOPE_TWO: assert property ($stable(slope_comp_code_out_two) |->
    slope_kohm_out_two == slp(slope_comp_code_out_two)) else $error("slope two decode wrong");
  AST_SENSE: assert property ($stable({sense_res_code_drv_four, sense_res_code_drv_one}) |->
    sense_ohm_drv[10:0] == sns(sense_res_code_drv_one) && sense_ohm_drv[43:33] == sns(sense_res_code_drv_four))
    else $error("sense resistor decode wrong");
  AST_OFF_ONE: assert property (!out_one_on [*2] |-> target_mv_out_one == 17'h00000)
    else $error("output one target not zero while off");
  AST_OFF_TWO: assert property (!out_two_on [*2] |-> target_mv_out_two == 17'h00000)
    else $error("output two target not zero while off");
  AST_ON_ONE: assert property (out_one_on [*2] |-> target_mv_out_one != 17'h00000)
    else $error("output one on with zero target");
  AST_HOLD: assert property (spi_cs_n [*8] |-> $stable({kp_code_out_one, ki_code_out_two, slope_comp_code_out_one}))
    else $error("register changed without a frame");
  cover property ($rose(out_one_on));
  cover property ($rose(out_two_on));
  cover property (kp_code_out_two == 4'hF);
endmodule // blv_config_regs_monitor
bind blv_config_regs blv_config_regs_monitor blv_config_regs_monitor_inst (.*);

// >>> tb/blv_spi_host.sv
// Purpose: spi host model sending mode 0 frames to the register block
// Assumes: frame is rw bit, 7-bit address, 8-bit data, msb first
// Notes:   sclk idles low between frames; released mosi shows the inverse bit
`timescale 1ns/100ps
module blv_spi_host (
  // clock
  input  wire logic core_clk,
  // spi pins
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // one whole frame, read data caught on the last eight rises
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    spi_cs_n = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = f[i];
      tick(6);
      spi_sclk = 1'b1;
      if (i < 8) rd[i] = spi_miso;
      tick(6);
      spi_sclk = 1'b0;
    end
    spi_mosi = ~spi_mosi;
    tick(6);
    spi_cs_n = 1'b1;
    tick(8);
  endtask
endmodule // blv_spi_host

// >>> tb/test_boost_loop_voltage_config_regs.sv
// Purpose: self-checking bench for the loop and target voltage registers
// Assumes: 200 MHz core clock, spi host model sends the frames
// Notes:   after the reset check, each scenario writes over spi then judges the decoded ports or the read data
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module test_boost_loop_voltage_config_regs;
  logic        core_clk, reset, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, out_one_on, out_two_on;
  logic [7:0]  tj_code, rd, kp_out_one, kp_out_two, ki_out_one, ki_out_two, slope_kohm_out_one, slope_kohm_out_two;
  logic [3:0]  kp_code_out_one, kp_code_out_two, ki_code_out_one, ki_code_out_two;
  logic [3:0]  slope_comp_code_out_one, slope_comp_code_out_two;
  logic [1:0]  sense_res_code_drv_one, sense_res_code_drv_two, sense_res_code_drv_three, sense_res_code_drv_four;
  logic [43:0] sense_ohm_drv;
  logic [16:0] target_mv_out_one, target_mv_out_two;
  int          fail_count = 0, checks = 0, cycles = 0;
  logic        oe_seen = 1'b0;
  blv_config_regs blv_config_regs_inst (.*);
  blv_spi_host blv_spi_host_inst (.*);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end
  always @(posedge core_clk) begin
    if (!spi_cs_n && spi_miso_oe === 1'b1) oe_seen <= 1'b1;
  end
  task automatic test_done;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // loop settings are picked freely by the host
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    blv_spi_host_inst.xfer({1'b1, a, d}, rd);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    blv_spi_host_inst.xfer({1'b0, a, 8'h00}, rd);
    `CHK(rd, e)
  endtask
  task automatic t_reset_vals;
    `CHK({kp_out_one, kp_out_two, ki_out_one, ki_out_two}, 32'h0A0A0A0A)
    `CHK({slope_kohm_out_one, slope_kohm_out_two}, 16'h7070)
    `CHK(sense_ohm_drv, {4{11'h0FA}})
    `CHK({out_one_on, out_two_on, target_mv_out_one, target_mv_out_two}, 36'h0)
    `CHK(spi_miso_oe, 1'b0)
  endtask
  task automatic t_gains;
    wr(7'h11, 8'hF0);
    `CHK({kp_code_out_two, kp_code_out_one, kp_out_two, kp_out_one}, 24'hF0A00A)
    wr(7'h11, 8'h73);
    `CHK({kp_out_two, kp_out_one}, 16'h5028)
    wr(7'h12, 8'h0F);
    `CHK({ki_code_out_two, ki_code_out_one, ki_out_two, ki_out_one}, 24'h0F0AA0)
    rdchk(7'h11, 8'h73);
  endtask
  task automatic t_slope;
    logic [3:0] c[5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8};
    logic [7:0] k[5] = '{8'h70, 8'h54, 8'h46, 8'h38, 8'h1C};
    wr(7'h13, 8'h3F);
    `CHK({slope_comp_code_out_two, slope_comp_code_out_one, slope_kohm_out_two, slope_kohm_out_one}, 24'h3F7070)
    for (int i = 0; i < 5; i++) begin
      wr(7'h13, {c[i], c[4 - i]});
      `CHK({slope_kohm_out_two, slope_kohm_out_one}, {k[i], k[4 - i]})
      `CHK({slope_comp_code_out_two, slope_comp_code_out_one}, {c[i], c[4 - i]})
    end
  endtask
  task automatic t_sense;
    wr(7'h14, 8'hE4);
    `CHK({sense_res_code_drv_four, sense_res_code_drv_three}, 4'hE)
    `CHK({sense_res_code_drv_two, sense_res_code_drv_one}, 4'h4)
    `CHK(sense_ohm_drv, {11'h5DC, 11'h3E8, 11'h1F4, 11'h0FA})
  endtask
  task automatic t_targets;
    wr(7'h03, 8'hFF);
    `CHK({out_one_on, target_mv_out_one}, {1'b1, 17'h1621C})
    tj_code = 8'h8A;
    wr(7'h04, 8'h02);
    `CHK({out_two_on, target_mv_out_two}, {1'b1, 17'h002DE})
    wr(7'h03, 8'h00);
    `CHK({out_one_on, target_mv_out_one}, 18'h0)
    rdchk(7'h04, 8'h02);
    wr(7'h04, 8'h00);
    `CHK({out_two_on, target_mv_out_two}, 18'h0)
  endtask
  task automatic t_unmapped;
    wr(7'h05, 8'h5A);
    rdchk(7'h05, 8'h00);
    rdchk(7'h13, 8'h80);
    rdchk(7'h14, 8'hE4);
    `CHK(oe_seen, 1'b1)
  endtask
  initial begin
    reset = 1'b1;
    tj_code = 8'h26;
    repeat (10) @(posedge core_clk);
    #1 reset = 1'b0;
    t_reset_vals();
    t_gains();
    t_slope();
    t_sense();
    t_targets();
    t_unmapped();
    test_done();
  end
endmodule // test_boost_loop_voltage_config_regs
